// >>> hdl/somfm_top.sv
// switching-output logic with on counters and fault monitor, apb slave
//
// Function
// R1 - direction bit set in init: channel drives
// R2 - output level follows cyclic output bit
// R3 - later direction change needs apply flag
// R4 - count off-to-on transitions, 0 to 65535
// R5 - counter wraps from 65535 to zero
// R6 - counts kept on device swap, cleared power-off
// R7 - writing zero clears counter; count readable
// R8 - pulses need 10ms on and off; counter takes every edge, no minimum width
// R9 - logic supply at/below 18V: flag, red
// R10 - drive supply at/below 18V: flag, flashing
// R11 - drive supply at/below 11V: flag, steady
// R12 - drive judgement valid only with logic ok
// R13 - short circuit: limit current, keep output
// R14 - leave limit when current back below threshold
// R15 - short at 1.6A power, 3A signal
// R16 - short sets signal and power flags
// R17 - monitoring always on, no enable
// R18 - init done: clear needed, set ready
// R19 - fault flags mirror present condition
`timescale 1ns/1ns
`default_nettype none
module somfm_top #(
   parameter logic [somfm_pkg::DIV_W-1:0] FLASH_CYCLES = somfm_pkg::DIV_W'(somfm_pkg::FLASH_CYC)
) (
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   input  wire logic                        psel_i,
   input  wire logic                        penable_i,
   input  wire logic                        pwrite_i,
   input  wire logic [somfm_pkg::AW-1:0]    paddr_i,
   input  wire logic [somfm_pkg::DW-1:0]    pwdata_i,
   output logic [somfm_pkg::DW-1:0]         prdata_o,
   output logic                             pready_o,
   output logic                             pslverr_o,
   input  wire logic                        logic_supply_le18v_i,
   input  wire logic                        drive_supply_le18v_i,
   input  wire logic                        drive_supply_le11v_i,
   input  wire logic [somfm_pkg::NCH-1:0]   signal_pins_ge3a_i,
   input  wire logic [somfm_pkg::NPORT-1:0] sensor_power_ge1p6a_i,
   output logic [somfm_pkg::NCH-1:0]        signal_pins_level_o,
   output logic [somfm_pkg::NCH-1:0]        signal_pins_drive_en_o,
   output logic [somfm_pkg::NCH-1:0]        current_limit_o,
   output logic                             logic_supply_led_red_o,
   output logic                             drive_supply_led_red_o,
   output logic                             irq_o
);
   import somfm_pkg::*;

   somfm_state_t      state_q;
   logic [NCH-1:0]    dir_cmd_q;
   logic [NCH-1:0]    out_bits_q;
   logic [NCH-1:0]    act_dir_q;
   logic [NCH-1:0]    sig_short_q;
   logic [NPORT-1:0]  pwr_short_q;
   logic [NIRQ-1:0]   irq_stat_q;
   logic [NIRQ-1:0]   irq_mask_q;
   logic [NIRQ-1:0]   irq_event;
   logic [2:0]        sup_prev_q;
   logic              logic_low;
   logic              drive_low;
   logic              drive_crit;
   logic              setup;
   logic              acc_wr;
   logic              wr_ctrl;
   logic              apply;
   logic              init_done;
   logic              hit_cnt;
   logic [3:0]        cnt_idx;
   logic [CW-1:0]     count [NCH];
   logic [DW-1:0]     rdata;
   logic              rerr;
   logic              run;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   assign setup     = psel_i & ~penable_i;
   assign acc_wr    = psel_i & penable_i & pready_o & pwrite_i;
   assign hit_cnt   = (paddr_i[AW-1:CNT_BLK_LSB] == CNT_BLOCK);
   assign cnt_idx   = paddr_i[CNT_IDX_MSB:CNT_IDX_LSB];
   assign wr_ctrl   = acc_wr && (paddr_i == ADDR_CTRL);
   assign apply     = wr_ctrl && pwdata_i[CTRL_APPLY];
   assign init_done = wr_ctrl && pwdata_i[CTRL_INIT_DONE];
   assign run       = (state_q == S_RUN);

   // zero wait: ready rises in the access cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
      end else begin
         pready_o <= setup;
      end
   end

   always_comb begin
      rdata = RD_ZERO;
      rerr  = 1'b0;
      if (hit_cnt) begin
         rdata[CW-1:0] = count[cnt_idx]; // see R7
      end else begin
         case (paddr_i)
            ADDR_CTRL: begin
               rdata[CTRL_INIT_DONE] = run;
            end
            ADDR_DIR_CMD: begin
               rdata[NCH-1:0] = dir_cmd_q;
            end
            ADDR_OUT_BITS: begin
               rdata[NCH-1:0] = out_bits_q;
            end
            ADDR_STATUS: begin
               rdata[ST_INIT_NEEDED] = ~run;
               rdata[ST_READY]       = run;
               rdata[ST_LOGIC_LOW]   = logic_low;
               rdata[ST_DRIVE_LOW]   = drive_low;
               rdata[ST_DRIVE_CRIT]  = drive_crit;
            end
            ADDR_SIG_SHORT: begin
               rdata[NCH-1:0] = sig_short_q;
            end
            ADDR_PWR_SHORT: begin
               rdata[NPORT-1:0] = pwr_short_q;
            end
            ADDR_ACT_DIR: begin
               rdata[NCH-1:0] = act_dir_q;
            end
            ADDR_IRQ_STAT: begin
               rdata[NIRQ-1:0] = irq_stat_q;
            end
            ADDR_IRQ_MASK: begin
               rdata[NIRQ-1:0] = irq_mask_q;
            end
            default: begin
               rerr = 1'b1;
            end
         endcase
      end
   end

   // read data sampled in setup, shown through the access cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prdata_o  <= RD_ZERO;
         pslverr_o <= 1'b0;
      end else if (setup) begin
         prdata_o  <= pwrite_i ? RD_ZERO : rdata;
         pslverr_o <= rerr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // writable registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_cmd_q  <= '0;
         out_bits_q <= '0;
         irq_mask_q <= '0;
      end else if (acc_wr) begin
         case (paddr_i)
            ADDR_DIR_CMD: begin
               dir_cmd_q <= pwdata_i[NCH-1:0];
            end
            ADDR_OUT_BITS: begin
               out_bits_q <= pwdata_i[NCH-1:0];
            end
            ADDR_IRQ_MASK: begin
               irq_mask_q <= pwdata_i[NIRQ-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // initial processing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= S_INIT;
      end else begin
         case (state_q)
            S_INIT: begin
               if (init_done) begin
                  state_q <= S_RUN; // see R18
               end
            end
            S_RUN: begin
               state_q <= S_RUN;
            end
            default: begin
               state_q <= S_INIT;
            end
         endcase
      end
   end

   // direction tracks the command in init, later only on apply
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_dir_q <= '0;
      end else if (!run || apply) begin
         act_dir_q <= dir_cmd_q; // see R1 see R3
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output drive and current limit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         signal_pins_drive_en_o <= '0;
         signal_pins_level_o    <= '0;
         current_limit_o        <= '0;
      end else begin
         signal_pins_drive_en_o <= run ? act_dir_q : '0; // see R1
         signal_pins_level_o    <= run ? (act_dir_q & out_bits_q) : '0; // see R2 see R13
         current_limit_o        <= signal_pins_ge3a_i & act_dir_q; // see R13 see R14
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // short flags mirror the comparators
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sig_short_q <= '0;
         pwr_short_q <= '0;
      end else begin
         sig_short_q <= signal_pins_ge3a_i; // see R15 see R16 see R17 see R19
         pwr_short_q <= sensor_power_ge1p6a_i; // see R15 see R16 see R19
      end
   end

   somfm_supply_mon #(
      .FLASH_CYCLES    (FLASH_CYCLES)
   ) somfm_supply_mon_inst (
      .clk_i           (clk_i),
      .rst_i           (rst_i),
      .logic_le18v_i   (logic_supply_le18v_i),
      .drive_le18v_i   (drive_supply_le18v_i),
      .drive_le11v_i   (drive_supply_le11v_i),
      .logic_low_o     (logic_low),
      .drive_low_o     (drive_low),
      .drive_crit_o    (drive_crit),
      .logic_led_red_o (logic_supply_led_red_o),
      .drive_led_red_o (drive_supply_led_red_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // on counters
   // a written zero clears; any other value leaves the count
   for (genvar i = 0; i < NCH; i++) begin : g_cnt
      somfm_on_counter somfm_on_counter_inst (
         .clk_i   (clk_i),
         .rst_i   (rst_i),
         .level_i (signal_pins_level_o[i]),
         .clr_i   (acc_wr && hit_cnt && (cnt_idx == 4'(i)) && (pwdata_i[CW-1:0] == CNT_ZERO)), // see R7
         .count_o (count[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: sticky, write one to clear, set wins
   // events are rises of a flag against its registered copy
   always_comb begin
      irq_event                 = '0;
      irq_event[IRQ_LOGIC_LOW]  = logic_low & ~sup_prev_q[0];
      irq_event[IRQ_DRIVE_LOW]  = drive_low & ~sup_prev_q[1];
      irq_event[IRQ_DRIVE_CRIT] = drive_crit & ~sup_prev_q[2];
      irq_event[IRQ_SIG_SHORT]  = |(signal_pins_ge3a_i & ~sig_short_q);
      irq_event[IRQ_PWR_SHORT]  = |(sensor_power_ge1p6a_i & ~pwr_short_q);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sup_prev_q <= '0;
         irq_stat_q <= '0;
         irq_o      <= 1'b0;
      end else begin
         sup_prev_q <= {drive_crit, drive_low, logic_low};
         if (acc_wr && (paddr_i == ADDR_IRQ_STAT)) begin
            irq_stat_q <= (irq_stat_q & ~pwdata_i[NIRQ-1:0]) | irq_event;
         end else begin
            irq_stat_q <= irq_stat_q | irq_event;
         end
         irq_o <= |(irq_stat_q & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_dir_hold_run: assert property (run && !apply |=> act_dir_q == $past(act_dir_q)) // see R3
      else $error("direction changed without apply");
   chk_dir_apply_latch: assert property (run && apply |=> act_dir_q == $past(dir_cmd_q) ##1 // see R3
                                         signal_pins_drive_en_o == $past(act_dir_q))
      else $error("apply did not latch direction");
   chk_init_to_ready: assert property (!run && init_done |=> run ##1 signal_pins_drive_en_o == $past(act_dir_q)) // see R18
      else $error("init done did not make station ready");
   chk_output_follow: assert property (run && $stable(act_dir_q) && $stable(out_bits_q) [*2] |-> // see R2
                                       signal_pins_level_o == (act_dir_q & out_bits_q))
      else $error("output level not following output bits");
   chk_no_drive_init: assert property (!run && !$past(run) |-> signal_pins_drive_en_o == '0) // see R1
      else $error("output driven before initial processing ended");
   chk_short_flag_set: assert property ($rose(signal_pins_ge3a_i[0]) |=> sig_short_q[0] && irq_stat_q[IRQ_SIG_SHORT]) // see R16
      else $error("signal short not flagged");
   chk_short_flag_clear: assert property ($fell(sensor_power_ge1p6a_i[0]) |=> !pwr_short_q[0]) // see R19
      else $error("sensor power short flag stuck");
   chk_limit_keeps_on: assert property (run && current_limit_o[0] && out_bits_q[0] && $past(out_bits_q[0]) // see R13
                                        && $past(run) |-> signal_pins_level_o[0])
      else $error("output dropped during current limit");
   chk_irq_level_out: assert property (|(irq_stat_q & irq_mask_q) |=> irq_o)
      else $error("interrupt not raised");
   chk_irq_low_out: assert property (!(|(irq_stat_q & irq_mask_q)) |=> !irq_o)
      else $error("interrupt raised with nothing pending");
   chk_pwr_flag_set: assert property ($rose(sensor_power_ge1p6a_i[0]) |=> pwr_short_q[0] && // see R16
                                      irq_stat_q[IRQ_PWR_SHORT])
      else $error("sensor power short not flagged");
   chk_sig_flag_clear: assert property ($fell(signal_pins_ge3a_i[0]) |=> !sig_short_q[0]) // see R19
      else $error("signal short flag stuck");
   chk_limit_out_only: assert property ((current_limit_o & ~$past(act_dir_q)) == '0) // see R13
      else $error("current limit on an input channel");
   chk_level_in_drive: assert property ((signal_pins_level_o & ~signal_pins_drive_en_o) == '0) // see R1
      else $error("output level on a channel not driven");
   chk_run_sticky: assert property (run |=> run) // see R18
      else $error("station left ready state");

   // bus timing: ready for one access cycle, read data held to the next setup
   chk_apb_ready_access: assert property (setup |=> pready_o)
      else $error("ready missing in access cycle");
   chk_apb_ready_once: assert property (pready_o |=> !pready_o)
      else $error("ready held past the access cycle");
   chk_rdata_hold: assert property (!setup |=> $stable(prdata_o) && $stable(pslverr_o))
      else $error("read data changed outside setup");

   cov_apply_change: cover property (run && apply && (dir_cmd_q != act_dir_q));
   cov_short_irq: cover property (irq_event[IRQ_SIG_SHORT] && irq_mask_q[IRQ_SIG_SHORT]);
   cov_crit_drive: cover property (drive_crit && run);
   cov_count_clear: cover property (acc_wr && hit_cnt && (pwdata_i[CW-1:0] == CNT_ZERO));
endmodule : somfm_top
`default_nettype wire

// >>> hdl/somfm_pkg.sv
// constants and types shared by the output and fault monitor
package somfm_pkg;
   localparam int NCH       = 16;
   localparam int NPORT     = 8;
   localparam int AW        = 12;
   localparam int DW        = 32;
   localparam int CW        = 16;
   localparam int NIRQ      = 5;
   localparam int DIV_W     = 24;
   localparam int CLK_HZ    = 10_000_000;
   localparam int FLASH_MS  = 250;
   localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);

   localparam logic [AW-1:0] ADDR_CTRL      = 12'h000;
   localparam logic [AW-1:0] ADDR_DIR_CMD   = 12'h004;
   localparam logic [AW-1:0] ADDR_OUT_BITS  = 12'h008;
   localparam logic [AW-1:0] ADDR_STATUS    = 12'h00C;
   localparam logic [AW-1:0] ADDR_SIG_SHORT = 12'h010;
   localparam logic [AW-1:0] ADDR_PWR_SHORT = 12'h014;
   localparam logic [AW-1:0] ADDR_ACT_DIR   = 12'h018;
   localparam logic [AW-1:0] ADDR_IRQ_STAT  = 12'h01C;
   localparam logic [AW-1:0] ADDR_IRQ_MASK  = 12'h020;
   localparam logic [5:0]    CNT_BLOCK      = 6'h01;
   localparam int            CNT_BLK_LSB    = 6;
   localparam int            CNT_IDX_LSB    = 2;
   localparam int            CNT_IDX_MSB    = 5;

   localparam int CTRL_INIT_DONE = 0;
   localparam int CTRL_APPLY     = 1;
   localparam int ST_INIT_NEEDED = 0;
   localparam int ST_READY       = 1;
   localparam int ST_LOGIC_LOW   = 2;
   localparam int ST_DRIVE_LOW   = 3;
   localparam int ST_DRIVE_CRIT  = 4;
   localparam int IRQ_LOGIC_LOW  = 0;
   localparam int IRQ_DRIVE_LOW  = 1;
   localparam int IRQ_DRIVE_CRIT = 2;
   localparam int IRQ_SIG_SHORT  = 3;
   localparam int IRQ_PWR_SHORT  = 4;

   localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CW-1:0] CNT_ONE  = 16'h0001;
   localparam logic [CW-1:0] CNT_MAX  = 16'hFFFF;
   localparam logic [DW-1:0] RD_ZERO  = 32'h0000_0000;

   typedef enum logic {S_INIT, S_RUN} somfm_state_t;
endpackage : somfm_pkg

// >>> hdl/somfm_on_counter.sv
// per-channel wrapping count of output off-to-on transitions
`timescale 1ns/1ns
`default_nettype none
module somfm_on_counter (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   level_i,
   input  wire logic                   clr_i,
   output logic [somfm_pkg::CW-1:0]    count_o
);
   import somfm_pkg::*;

   logic          prev_q;
   logic          rise;
   logic [CW-1:0] count_q;

   assign rise    = level_i & ~prev_q;
   assign count_o = count_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level_i;
      end
   end

   // reset or a written zero clears; a clear and an edge together leave one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_q <= CNT_ZERO; // see R6
      end else if (clr_i) begin
         count_q <= rise ? CNT_ONE : CNT_ZERO; // see R7
      end else if (rise) begin
         count_q <= (count_q == CNT_MAX) ? CNT_ZERO : count_q + CNT_ONE; // see R4 see R5
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_cnt_wrap_zero: assert property ((count_q == CNT_MAX) && rise && !clr_i |=> count_q == CNT_ZERO) // see R5
      else $error("on counter did not wrap to zero");
   chk_cnt_step_one: assert property (rise && !clr_i && (count_q != CNT_MAX) |=> count_q == $past(count_q) + CNT_ONE) // see R4
      else $error("on counter did not step by one");
   chk_cnt_clear_zero: assert property (clr_i && !rise |=> (count_q == CNT_ZERO) [*1] ##1 (count_q <= CNT_ONE)) // see R7
      else $error("on counter not cleared");
   cov_cnt_wrap: cover property ((count_q == CNT_MAX) && rise);
endmodule : somfm_on_counter
`default_nettype wire

// >>> hdl/somfm_supply_mon.sv
// supply undervoltage flags and indicator drive
`timescale 1ns/1ns
`default_nettype none
module somfm_supply_mon #(
   parameter logic [somfm_pkg::DIV_W-1:0] FLASH_CYCLES = somfm_pkg::DIV_W'(somfm_pkg::FLASH_CYC)
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic logic_le18v_i,
   input  wire logic drive_le18v_i,
   input  wire logic drive_le11v_i,
   output logic      logic_low_o,
   output logic      drive_low_o,
   output logic      drive_crit_o,
   output logic      logic_led_red_o,
   output logic      drive_led_red_o
);
   import somfm_pkg::*;

   logic [DIV_W-1:0] div_q;
   logic             blink_q;
   logic             tick;

   assign tick = (div_q == FLASH_CYCLES - DIV_W'(1));

   // flash rate divider
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q   <= '0;
         blink_q <= 1'b0;
      end else if (tick) begin
         div_q   <= '0;
         blink_q <= ~blink_q;
      end else begin
         div_q   <= div_q + DIV_W'(1);
      end
   end

   // always active; drive judgement only with a healthy logic supply
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         logic_low_o     <= 1'b0;
         drive_low_o     <= 1'b0;
         drive_crit_o    <= 1'b0;
         logic_led_red_o <= 1'b0;
         drive_led_red_o <= 1'b0;
      end else begin
         logic_low_o     <= logic_le18v_i; // see R9 see R17 see R19
         drive_low_o     <= drive_le18v_i & ~logic_le18v_i; // see R10 see R12
         drive_crit_o    <= drive_le11v_i & ~logic_le18v_i; // see R11 see R12
         logic_led_red_o <= logic_le18v_i; // see R9
         drive_led_red_o <= ~logic_le18v_i & (drive_le11v_i | (drive_le18v_i & blink_q)); // see R10 see R11
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_drive_gate_logic: assert property (logic_low_o |-> !drive_low_o && !drive_crit_o) // see R12
      else $error("drive flag raised with logic supply low");
   chk_crit_led_steady: assert property (drive_crit_o |-> drive_led_red_o) // see R11
      else $error("critical drive supply without steady red");
   chk_logic_flag_follow: assert property ($rose(logic_le18v_i) |=> logic_low_o && logic_led_red_o) // see R9
      else $error("logic supply low flag missing");
endmodule : somfm_supply_mon
`default_nettype wire

// >>> bench/somfm_field_model.sv
// field-side model: loads and shorts on the switching outputs
`timescale 1ns/1ns
`default_nettype none
module somfm_field_model (
   input  wire logic [somfm_pkg::NCH-1:0]   drive_en_i,
   input  wire logic [somfm_pkg::NCH-1:0]   level_i,
   input  wire logic [somfm_pkg::NCH-1:0]   sig_short_i,
   input  wire logic [somfm_pkg::NPORT-1:0] pwr_short_i,
   output logic [somfm_pkg::NCH-1:0]        ge3a_o,
   output logic [somfm_pkg::NPORT-1:0]      ge1p6a_o
);
   import somfm_pkg::*;
   // a shorted pin only draws current while driven on
   assign ge3a_o   = sig_short_i & drive_en_i & level_i;
   assign ge1p6a_o = pwr_short_i;
endmodule : somfm_field_model
`default_nettype wire

// >>> bench/tb_somfm_top.sv
// self-checking bench for the output and fault monitor
`timescale 1ns/1ns
`default_nettype none
module tb_somfm_top;
   import somfm_pkg::*;
   logic            clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
   logic [AW-1:0]   paddr;
   logic [DW-1:0]   pwdata, prdata;
   logic            log18, drv18, drv11, log_led, drv_led, irq;
   logic [NCH-1:0]  ge3a, sig_short, level, drive_en, climit;
   logic [NPORT-1:0] ge1p6a, pwr_short;
   int              error_cnt = 0;
   int              compares = 0;
   int              cyc = 0;
   ////////////////////////////////////////////////////////////////
   somfm_top #(.FLASH_CYCLES(DIV_W'(4))) somfm_top_inst (
      .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .logic_supply_le18v_i(log18), .drive_supply_le18v_i(drv18), .drive_supply_le11v_i(drv11),
      .signal_pins_ge3a_i(ge3a), .sensor_power_ge1p6a_i(ge1p6a), .signal_pins_level_o(level),
      .signal_pins_drive_en_o(drive_en), .current_limit_o(climit), .logic_supply_led_red_o(log_led),
      .drive_supply_led_red_o(drv_led), .irq_o(irq));
   somfm_field_model somfm_field_model_inst (
      .drive_en_i(drive_en), .level_i(level), .sig_short_i(sig_short), .pwr_short_i(pwr_short),
      .ge3a_o(ge3a), .ge1p6a_o(ge1p6a));
   ////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   always @(posedge clk_i) begin
      cyc++;
      if (cyc >= 5000) begin
         error_cnt++;
         $display("Error at %0t: timeout", $time);
         test_done();
      end
   end
   task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] x, input string m);
      compares++;
      if (g !== x) begin
         error_cnt++;
         $display("Error at %0t: %s got %h exp %h", $time, m, g, x);
      end
   endtask : chk
   // one transfer, request held until pready seen high
   task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
                      output logic [DW-1:0] r, output logic e);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1);
      chk(DW'(n), 32'h1, "ready wait");
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask : apb
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      logic [DW-1:0] r;
      logic          e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] x, input string m);
      logic [DW-1:0] r;
      logic          e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x, m);
   endtask : rd
   task automatic flashes(output int t);
      logic p;
      t = 0;
      p = drv_led;
      repeat (16) begin
         @(posedge clk_i);
         if (drv_led !== p)
            t++;
         p = drv_led;
      end
   endtask : flashes
   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [DW-1:0] r;
      logic          e;
      rd(ADDR_STATUS, 32'h1, "status after reset");
      chk(DW'(drive_en), 32'h0, "drive off");
      apb(1'b0, 12'h0FC, 32'h0, r, e);
      chk(DW'(e), 32'h1, "unmapped error");
      chk(r, 32'h0, "unmapped data");
   endtask : t_reset
   task automatic t_init();
      wr(ADDR_DIR_CMD, 32'h00FF);
      wr(ADDR_OUT_BITS, 32'h0005);
      repeat (4) @(posedge clk_i);
      chk(DW'(drive_en), 32'h0, "no drive in init");
      wr(ADDR_CTRL, 32'h1);
      repeat (4) @(posedge clk_i);
      rd(ADDR_STATUS, 32'h2, "ready status");
      chk(DW'(drive_en), 32'h00FF, "direction");
      chk(DW'(level), 32'h0005, "output level");
   endtask : t_init
   task automatic t_dir();
      wr(ADDR_DIR_CMD, 32'h0F0F);
      repeat (4) @(posedge clk_i);
      chk(DW'(drive_en), 32'h00FF, "dir held");
      wr(ADDR_CTRL, 32'h2);
      repeat (4) @(posedge clk_i);
      chk(DW'(drive_en), 32'h0F0F, "dir applied");
      rd(ADDR_ACT_DIR, 32'h0F0F, "active dir");
      chk(DW'(level), 32'h0005, "level kept");
   endtask : t_dir
   task automatic t_count();
      rd(12'h048, 32'h1, "count ch2");
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_OUT_BITS, 32'h0004);
         wr(ADDR_OUT_BITS, 32'h0005); // short pulses, this counter takes every edge
      end
      repeat (2) @(posedge clk_i);
      rd(12'h040, 32'h4, "count ch0");
      wr(12'h040, 32'h5);
      rd(12'h040, 32'h4, "nonzero write");
      wr(12'h040, 32'h0);
      rd(12'h040, 32'h0, "cleared");
   endtask : t_count
   task automatic t_supply();
      int t;
      wr(ADDR_IRQ_MASK, 32'h1);
      log18 <= 1'b1;
      drv18 <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(ADDR_STATUS, 32'h6, "logic low");
      chk(DW'({log_led, drv_led, irq}), 32'h5, "led irq");
      wr(ADDR_IRQ_STAT, 32'h1);
      repeat (3) @(posedge clk_i);
      chk(DW'(irq), 32'h0, "irq cleared");
      log18 <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd(ADDR_STATUS, 32'hA, "drive low");
      rd(ADDR_IRQ_STAT, 32'h2, "irq status");
      chk(DW'(irq), 32'h0, "irq masked");
      flashes(t);
      chk(DW'(t >= 3 && t <= 4), 32'h1, "flashing");
      drv11 <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(ADDR_STATUS, 32'h1A, "drive critical");
      flashes(t);
      chk(DW'({t == 0, drv_led}), 32'h3, "steady");
      drv18 <= 1'b0;
      drv11 <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd(ADDR_STATUS, 32'h2, "supplies ok");
      wr(ADDR_IRQ_STAT, 32'h1F);
   endtask : t_supply
   task automatic t_short();
      sig_short <= 16'h0001;
      pwr_short <= 8'h05;
      repeat (4) @(posedge clk_i);
      rd(ADDR_SIG_SHORT, 32'h1, "signal short");
      rd(ADDR_PWR_SHORT, 32'h5, "power short");
      chk(DW'(climit), 32'h1, "limiter on");
      chk(DW'(level), 32'h0005, "output kept");
      rd(ADDR_IRQ_STAT, 32'h18, "short events");
      sig_short <= 16'h0000;
      pwr_short <= 8'h00;
      repeat (4) @(posedge clk_i);
      chk(DW'(climit), 32'h0, "limiter off");
      rd(ADDR_SIG_SHORT, 32'h0, "short gone");
      rd(ADDR_PWR_SHORT, 32'h0, "power short gone");
   endtask : t_short
   task automatic t_power();
      rst_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rd(12'h048, 32'h0, "count after power");
      rd(ADDR_STATUS, 32'h1, "init again");
      chk(DW'(drive_en), 32'h0, "drive off");
   endtask : t_power
   ////////////////////////////////////////////////////////////////
   initial begin
      rst_i     <= 1'b1;
      {psel, penable, pwrite, log18, drv18, drv11} <= 6'h00;
      paddr     <= 12'h000;
      pwdata    <= 32'h0;
      sig_short <= 16'h0000;
      pwr_short <= 8'h00;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      t_reset();
      t_init();
      t_dir();
      t_count();
      t_supply();
      t_short();
      t_power();
      test_done();
   end
endmodule : tb_somfm_top
`default_nettype wire
